//--- rsa_defs.svh
// Purpose: shared constants for the two-wire rtc/eeprom access block
// Assumes: included by bare name from the device and host files only
// Notes: times are in their own units, cycle counts derive from them
`ifndef RSA_DEFS_SVH
`define RSA_DEFS_SVH
////////////////////////////////////////////////////////////////////////
// clocking and timing
`define RSA_CLK_MHZ 25
`define RSA_SCL_KHZ 400
`define RSA_QTR_CYC ((`RSA_CLK_MHZ * 1000) / (`RSA_SCL_KHZ * 4))
`define RSA_TWC_US 5000
////////////////////////////////////////////////////////////////////////
// slave byte fields and clock section unlock writes
`define RSA_SLV_ARR 7'h57
`define RSA_SLV_CCR 7'h6f
`define RSA_SR_ADDR 16'h003f
`define RSA_ULK_1 8'h02
`define RSA_ULK_2 8'h06
////////////////////////////////////////////////////////////////////////
// address space and pages
`define RSA_ARR_SZ 512
`define RSA_CCR_SZ 64
`define RSA_ARR_AW 9
`define RSA_CCR_AW 6
`define RSA_ARR_MASK 16'h01ff
`define RSA_CCR_MASK 16'h003f
`define RSA_APG_MASK 16'h000f
`define RSA_CPG_MASK 16'h0007
`define RSA_CPG_SZ 6'h08
`define RSA_WP_HI 8
`define RSA_WP_LO 7
////////////////////////////////////////////////////////////////////////
// write buffer
`define RSA_FW 18
`define RSA_FD 32
`define RSA_BITS 4'h8
`endif

//--- rsa_pkg.sv
// Purpose: types shared by both ends
// Assumes: nothing
// Notes: no constants here, see rsa_defs.svh
package rsa_pkg;
  typedef enum logic [1:0] {OP_WRITE, OP_RAND_RD, OP_CUR_RD, OP_SET_ADDR} rsa_op_e;
  typedef enum logic [2:0] {PH_IDLE, PH_SLAVE, PH_WAH, PH_WAL, PH_WDAT, PH_RDAT} rsa_ph_e;
  typedef enum logic [3:0] {H_IDLE, H_ST, H_SLV, H_AH, H_AL, H_DAT, H_SLR, H_RD, H_SP} rsa_hst_e;
endpackage

//--- rsa_if.sv
// Purpose: two-wire link between bus master and device
// Assumes: sda is open drain with a pull-up, scl driven by master only
// Notes: a low is pulled when any enabled driver outputs zero
`timescale 1ns/10ps
interface rsa_if;
  logic scl;
  logic h_sda_o;
  logic h_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic sda;
  assign sda = ((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o)) ? 1'b0 : 1'b1;
  modport host (output scl, output h_sda_o, output h_sda_oe, input sda);
  modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
endinterface

//--- rsa_fifo.sv
// Purpose: write buffer between the byte receiver and the nv store
// Assumes: single clock, flush discards everything held
// Notes: full and empty derive from pointers one bit wider than the index
`timescale 1ns/10ps
module rsa_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0] wp_reg;
  logic [AW:0] rp_reg;
  logic full;
  logic empty;
  assign empty = (wp_reg == rp_reg);
  assign full = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem[rp_reg[AW-1:0]];
  always_ff @(posedge clk) begin
    if (in_valid && !full) begin
      mem[wp_reg[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else if (flush) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      if (in_valid && !full) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (out_ready && !empty) begin
        rp_reg <= rp_reg + 1'b1;
      end
    end
  end
endmodule

//--- rsa_dev.sv
// Purpose: device end of the two-wire rtc/eeprom serial access
// Assumes: scl and sda are synchronous to clk and far slower than it
// Notes: written bytes are buffered and committed to storage while busy
// Contract
// R1: master unlocks clock section with 02h then 06h
// R2: ack both address bytes and data byte
// R3: ignore bus and release sda while busy
// R4: protected write acked but never committed
// R5: page write up to 16 array, 8 clock
// R6: master writes timekeeping only as 8-byte page
// R7: advance address after each acked write byte
// R8: write address wraps within 16 or 8 page
// R9: excess page bytes overwrite earlier wrapped bytes
// R10: early or mid-byte stop discards the write
// R11: withhold array slave ack while busy
// R12: master polls only with array slave byte
// R13: sixteen-bit read counter, zero at reset
// R14: read slave byte acked then eight bits sent
// R15: master ends read with nack then stop
// R16: random read uses dummy write then restart
// R17: stop after word address only loads counter
// R18: sequential read continues on master ack
// R19: read counter wraps at end of space
// R20: upper nibble selects array or clock section
// R21: word address is two bytes, high first
// R22: busy held for a configurable cycle count
`timescale 1ns/10ps
`include "rsa_defs.svh"
module rsa_dev #(
  parameter int unsigned TWC_CYC = `RSA_TWC_US * `RSA_CLK_MHZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // two-wire link
  rsa_if.dev bus,
  // user side
  input wire logic [3:0] wp_blocks,
  output logic busy,
  output logic nv_start
);
  ////////////////////////////////////////////////////////////////////
  // storage
  logic [7:0] mem_a [0:`RSA_ARR_SZ-1];
  logic [7:0] mem_c [0:`RSA_CCR_SZ-1];
  ////////////////////////////////////////////////////////////////////
  // state
  rsa_pkg::rsa_ph_e ph_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg;
  logic [7:0] tx_reg;
  logic [7:0] wa_hi_reg;
  logic [15:0] addr_reg;
  logic tgt_ccr_reg;
  logic got_data_reg;
  logic wp_hit_reg;
  logic mack_reg;
  logic rd_first_reg;
  logic oe_reg;
  logic scl_p_reg;
  logic sda_p_reg;
  logic [31:0] twc_reg;
  ////////////////////////////////////////////////////////////////////
  // line events
  logic rise;
  logic fall;
  logic start;
  logic stop;
  assign rise = bus.scl & ~scl_p_reg;
  assign fall = ~bus.scl & scl_p_reg;
  assign start = bus.scl & scl_p_reg & sda_p_reg & ~bus.sda;
  assign stop = bus.scl & scl_p_reg & ~sda_p_reg & bus.sda;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_p_reg <= 1'b1;
      sda_p_reg <= 1'b1;
    end else begin
      scl_p_reg <= bus.scl;
      sda_p_reg <= bus.sda;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // address arithmetic
  logic slv_match;
  logic [15:0] w_mask;
  logic [15:0] r_mask;
  logic [15:0] w_next;
  logic [15:0] r_next;
  logic [7:0] r_byte;
  logic prot;
  assign slv_match = (sh_reg[7:1] == `RSA_SLV_ARR) || (sh_reg[7:1] == `RSA_SLV_CCR); // R20
  assign w_mask = tgt_ccr_reg ? `RSA_CPG_MASK : `RSA_APG_MASK;
  assign r_mask = tgt_ccr_reg ? `RSA_CCR_MASK : `RSA_ARR_MASK;
  assign w_next = (addr_reg & ~w_mask) | ((addr_reg + 16'h0001) & w_mask); // R8
  assign r_next = (addr_reg + 16'h0001) & r_mask; // R19
  assign r_byte = tgt_ccr_reg ? mem_c[addr_reg[`RSA_CCR_AW-1:0]] : mem_a[addr_reg[`RSA_ARR_AW-1:0]];
  assign prot = ~tgt_ccr_reg & wp_blocks[addr_reg[`RSA_WP_HI:`RSA_WP_LO]];
  ////////////////////////////////////////////////////////////////////
  // write buffer
  logic push;
  logic f_ready;
  logic f_valid;
  logic [`RSA_FW-1:0] f_out;
  logic wr_end;
  logic go;
  logic flush;
  assign push = fall && (bit_reg == `RSA_BITS) && (ph_reg == rsa_pkg::PH_WDAT) && !busy;
  assign wr_end = (stop || start) && !busy && (ph_reg == rsa_pkg::PH_WDAT);
  // the scl rise that carries a stop counts one bit, so only a count of 0 or 1 means no partial byte
  assign go = stop && wr_end && got_data_reg && (bit_reg == 4'h0 || bit_reg == 4'h1) && !wp_hit_reg; // R2 R4 R10
  assign flush = wr_end && !go; // R10 R4
  rsa_fifo #(
    .WIDTH(`RSA_FW),
    .DEPTH(`RSA_FD)
  ) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .flush(flush),
    .in_valid(push),
    .in_ready(f_ready),
    .in_data({tgt_ccr_reg, addr_reg[`RSA_ARR_AW-1:0], sh_reg}),
    .out_valid(f_valid),
    .out_ready(busy),
    .out_data(f_out)
  );
  // drained in arrival order, so a later byte at a wrapped slot wins
  always_ff @(posedge clk) begin
    if (busy && f_valid) begin
      if (f_out[`RSA_FW-1]) begin
        mem_c[f_out[8 +: `RSA_CCR_AW]] <= f_out[7:0]; // R9
      end else begin
        mem_a[f_out[8 +: `RSA_ARR_AW]] <= f_out[7:0]; // R9
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // nonvolatile write timing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      nv_start <= 1'b0;
      twc_reg <= 32'h0;
    end else begin
      nv_start <= go;
      if (go) begin
        busy <= 1'b1; // R22
        twc_reg <= 32'h0;
      end else if (busy) begin
        twc_reg <= twc_reg + 32'h1;
        if (twc_reg == TWC_CYC - 32'h1) begin
          busy <= 1'b0; // R22
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // byte protocol
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_reg <= rsa_pkg::PH_IDLE;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      tx_reg <= 8'h00;
      wa_hi_reg <= 8'h00;
      addr_reg <= 16'h0000; // R13
      tgt_ccr_reg <= 1'b0;
      got_data_reg <= 1'b0;
      wp_hit_reg <= 1'b0;
      mack_reg <= 1'b0;
      rd_first_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else if (busy) begin
      ph_reg <= rsa_pkg::PH_IDLE; // R3 R11
      bit_reg <= 4'h0;
      oe_reg <= 1'b0; // R3
    end else if (start) begin
      ph_reg <= rsa_pkg::PH_SLAVE;
      bit_reg <= 4'h0;
      oe_reg <= 1'b0;
      got_data_reg <= 1'b0;
      wp_hit_reg <= 1'b0;
    end else if (stop) begin
      ph_reg <= rsa_pkg::PH_IDLE; // R17
      bit_reg <= 4'h0;
      oe_reg <= 1'b0;
    end else if (rise && ph_reg != rsa_pkg::PH_IDLE) begin
      if (bit_reg == `RSA_BITS) begin
        bit_reg <= 4'h0;
        mack_reg <= ~bus.sda;
      end else begin
        sh_reg <= {sh_reg[6:0], bus.sda};
        bit_reg <= bit_reg + 4'h1;
      end
    end else if (fall && ph_reg != rsa_pkg::PH_IDLE) begin
      if (bit_reg == `RSA_BITS && ph_reg != rsa_pkg::PH_RDAT) begin
        unique case (ph_reg)
          rsa_pkg::PH_SLAVE: begin
            oe_reg <= slv_match; // R11 R14
            if (slv_match) begin
              tgt_ccr_reg <= (sh_reg[7:1] == `RSA_SLV_CCR); // R20
              ph_reg <= sh_reg[0] ? rsa_pkg::PH_RDAT : rsa_pkg::PH_WAH;
              rd_first_reg <= 1'b1;
            end else begin
              ph_reg <= rsa_pkg::PH_IDLE;
            end
          end
          rsa_pkg::PH_WAH: begin
            oe_reg <= 1'b1; // R2 R21
            wa_hi_reg <= sh_reg;
            ph_reg <= rsa_pkg::PH_WAL;
          end
          rsa_pkg::PH_WAL: begin
            oe_reg <= 1'b1; // R2 R21
            addr_reg <= {wa_hi_reg, sh_reg}; // R16 R17
            ph_reg <= rsa_pkg::PH_WDAT;
          end
          default: begin
            // data byte of a write, acked only if the buffer took it
            oe_reg <= f_ready; // R2 R5
            if (f_ready) begin
              addr_reg <= w_next; // R7
              got_data_reg <= 1'b1;
              if (prot) begin
                wp_hit_reg <= 1'b1; // R4
              end
            end
          end
        endcase
      end else if (bit_reg == `RSA_BITS) begin
        oe_reg <= 1'b0;
      end else if (bit_reg == 4'h0) begin
        if (ph_reg == rsa_pkg::PH_RDAT && (rd_first_reg || mack_reg)) begin
          tx_reg <= r_byte; // R14 R18
          oe_reg <= ~r_byte[7];
          addr_reg <= r_next; // R18 R19
          rd_first_reg <= 1'b0;
        end else begin
          oe_reg <= 1'b0;
          if (ph_reg == rsa_pkg::PH_RDAT) begin
            ph_reg <= rsa_pkg::PH_IDLE; // R18
          end
        end
      end else if (ph_reg == rsa_pkg::PH_RDAT) begin
        tx_reg <= {tx_reg[6:0], 1'b0};
        oe_reg <= ~tx_reg[6];
      end
    end
  end
  assign bus.d_sda_oe = oe_reg;
  assign bus.d_sda_o = 1'b0;
endmodule

//--- rsa_host.sv
// Purpose: bus master end issuing writes, reads and completion polling
// Assumes: one command at a time, scl quarter period from a divider
// Notes: clock section writes are preceded by the two unlock writes
`timescale 1ns/10ps
`include "rsa_defs.svh"
module rsa_host (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // two-wire link
  rsa_if.host bus,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire rsa_pkg::rsa_op_e cmd_op,
  input wire logic cmd_ccr,
  input wire logic [15:0] cmd_addr,
  input wire logic [5:0] cmd_len,
  // write data
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  output logic wr_ready,
  // read data and status
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic done,
  output logic err
);
  rsa_pkg::rsa_hst_e st;
  rsa_pkg::rsa_op_e op_reg;
  logic ccr_reg;
  logic [15:0] addr_reg;
  logic [5:0] len_reg;
  logic [1:0] stage_reg;
  logic poll_reg;
  logic rs_reg;
  logic bad_reg;
  logic ack_reg;
  logic [1:0] q_reg;
  logic [3:0] bit_reg;
  logic [7:0] shr_reg;
  logic [7:0] dbyte_reg;
  logic scl_reg;
  logic oe_reg;
  logic tick;
  logic [7:0] div_reg;
  ////////////////////////////////////////////////////////////////////
  // quarter-period enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 8'h00;
      tick <= 1'b0;
    end else begin
      tick <= (div_reg == 8'(`RSA_QTR_CYC - 1));
      div_reg <= (div_reg == 8'(`RSA_QTR_CYC - 1)) ? 8'h00 : div_reg + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // byte to send
  logic ccr_tgt;
  logic [15:0] a_now;
  logic [7:0] txb;
  logic is_rx;
  logic wait_wr;
  assign ccr_tgt = ccr_reg | (stage_reg != 2'h2);
  assign a_now = (stage_reg != 2'h2) ? `RSA_SR_ADDR : addr_reg;
  assign is_rx = (st == rsa_pkg::H_RD);
  assign wait_wr = (st == rsa_pkg::H_DAT) && (stage_reg == 2'h2) && (bit_reg == 4'h0) && (q_reg == 2'h0);
  always_comb begin
    txb = 8'h00;
    unique case (st)
      rsa_pkg::H_SLV: txb = {(ccr_tgt && !poll_reg) ? `RSA_SLV_CCR : `RSA_SLV_ARR, 1'b0}; // R12
      rsa_pkg::H_SLR: txb = {ccr_tgt ? `RSA_SLV_CCR : `RSA_SLV_ARR, 1'b1}; // R16
      rsa_pkg::H_AH: txb = a_now[15:8]; // R21
      rsa_pkg::H_AL: txb = a_now[7:0];
      rsa_pkg::H_DAT: txb = (stage_reg == 2'h0) ? `RSA_ULK_1 : (stage_reg == 2'h1) ? `RSA_ULK_2
                          : (wait_wr ? wr_data : dbyte_reg); // R1
      default: txb = 8'h00;
    endcase
  end
  ////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= rsa_pkg::H_IDLE;
      op_reg <= rsa_pkg::OP_WRITE;
      ccr_reg <= 1'b0;
      addr_reg <= 16'h0000;
      len_reg <= 6'h00;
      stage_reg <= 2'h2;
      poll_reg <= 1'b0;
      rs_reg <= 1'b0;
      bad_reg <= 1'b0;
      ack_reg <= 1'b0;
      q_reg <= 2'h0;
      bit_reg <= 4'h0;
      shr_reg <= 8'h00;
      dbyte_reg <= 8'h00;
      scl_reg <= 1'b1;
      oe_reg <= 1'b0;
      cmd_ready <= 1'b0;
      wr_ready <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      done <= 1'b0;
      err <= 1'b0;
    end else begin
      wr_ready <= 1'b0;
      rd_valid <= 1'b0;
      done <= 1'b0;
      err <= 1'b0;
      if (st == rsa_pkg::H_IDLE) begin
        cmd_ready <= 1'b1;
        if (cmd_valid && cmd_ready) begin
          cmd_ready <= 1'b0;
          op_reg <= cmd_op;
          ccr_reg <= cmd_ccr;
          addr_reg <= cmd_addr;
          len_reg <= cmd_len;
          poll_reg <= 1'b0;
          rs_reg <= 1'b0;
          bad_reg <= 1'b0;
          stage_reg <= (cmd_op == rsa_pkg::OP_WRITE && cmd_ccr) ? 2'h0 : 2'h2;
          if ((cmd_op == rsa_pkg::OP_WRITE && cmd_ccr && cmd_len != `RSA_CPG_SZ) || cmd_len == 6'h00) begin
            err <= 1'b1; // R6
            done <= 1'b1;
          end else begin
            st <= rsa_pkg::H_ST;
          end
        end
      end else if (tick && !(wait_wr && !wr_valid)) begin
        q_reg <= q_reg + 2'h1;
        if (st == rsa_pkg::H_ST || st == rsa_pkg::H_SP) begin
          unique case (q_reg)
            2'h0: oe_reg <= (st == rsa_pkg::H_SP);
            2'h1: scl_reg <= 1'b1;
            2'h2: oe_reg <= (st == rsa_pkg::H_ST);
            default: begin
              scl_reg <= (st == rsa_pkg::H_SP);
              if (st == rsa_pkg::H_ST) begin
                st <= (rs_reg || (op_reg == rsa_pkg::OP_CUR_RD && !poll_reg)) ? rsa_pkg::H_SLR : rsa_pkg::H_SLV;
              end else if (bad_reg) begin
                done <= 1'b1;
                st <= rsa_pkg::H_IDLE;
              end else if (op_reg == rsa_pkg::OP_WRITE && !poll_reg) begin
                poll_reg <= 1'b1;
                st <= rsa_pkg::H_ST;
              end else if (poll_reg && !ack_reg) begin
                st <= rsa_pkg::H_ST;
              end else if (poll_reg && stage_reg != 2'h2) begin
                poll_reg <= 1'b0;
                stage_reg <= stage_reg + 2'h1; // R1
                st <= rsa_pkg::H_ST;
              end else begin
                done <= 1'b1;
                st <= rsa_pkg::H_IDLE;
              end
            end
          endcase
        end else begin
          unique case (q_reg)
            2'h0: begin
              if (is_rx) begin
                oe_reg <= (bit_reg == `RSA_BITS) && (len_reg != 6'h01); // R15 R18
              end else begin
                oe_reg <= (bit_reg != `RSA_BITS) && !txb[3'(4'h7 - bit_reg)];
              end
              if (wait_wr) begin
                dbyte_reg <= wr_data;
                wr_ready <= 1'b1;
              end
            end
            2'h1: scl_reg <= 1'b1;
            2'h2: begin
              if (bit_reg == `RSA_BITS) begin
                ack_reg <= ~bus.sda;
              end else begin
                shr_reg <= {shr_reg[6:0], bus.sda};
              end
            end
            default: begin
              scl_reg <= 1'b0;
              bit_reg <= (bit_reg == `RSA_BITS) ? 4'h0 : bit_reg + 4'h1;
              if (bit_reg == `RSA_BITS) begin
                unique case (st)
                  rsa_pkg::H_SLV: begin
                    if (!poll_reg && !ack_reg) begin
                      err <= 1'b1;
                      bad_reg <= 1'b1;
                    end
                    st <= (poll_reg || !ack_reg) ? rsa_pkg::H_SP : rsa_pkg::H_AH; // R12
                  end
                  rsa_pkg::H_AH: st <= rsa_pkg::H_AL;
                  rsa_pkg::H_AL: begin
                    if (stage_reg == 2'h2 && op_reg == rsa_pkg::OP_SET_ADDR) begin
                      st <= rsa_pkg::H_SP;
                    end else if (stage_reg == 2'h2 && op_reg == rsa_pkg::OP_RAND_RD) begin
                      rs_reg <= 1'b1;
                      st <= rsa_pkg::H_ST; // R16
                    end else begin
                      st <= rsa_pkg::H_DAT;
                    end
                  end
                  rsa_pkg::H_DAT: begin
                    if (stage_reg == 2'h2) begin
                      len_reg <= len_reg - 6'h01;
                    end
                    st <= (stage_reg != 2'h2 || len_reg == 6'h01) ? rsa_pkg::H_SP : rsa_pkg::H_DAT;
                  end
                  rsa_pkg::H_SLR: begin
                    rs_reg <= 1'b0;
                    if (!ack_reg) begin
                      err <= 1'b1;
                      bad_reg <= 1'b1;
                    end
                    st <= ack_reg ? rsa_pkg::H_RD : rsa_pkg::H_SP;
                  end
                  default: begin
                    rd_valid <= 1'b1;
                    rd_data <= shr_reg;
                    len_reg <= len_reg - 6'h01;
                    st <= (len_reg == 6'h01) ? rsa_pkg::H_SP : rsa_pkg::H_RD; // R15
                  end
                endcase
              end
            end
          endcase
        end
      end
    end
  end
  assign bus.scl = scl_reg;
  assign bus.h_sda_oe = oe_reg;
  assign bus.h_sda_o = 1'b0;
endmodule

//--- rsa_props.sv
// Purpose: link and device status checker for the serial pair
// Assumes: one clock domain, link signals seen as plain inputs
// Notes: busy span compared against TWC_CYC exactly
`timescale 1ns/10ps
module rsa_props #(
  parameter int unsigned TWC_CYC = 64
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link
  input wire logic scl,
  input wire logic h_sda_o,
  input wire logic h_sda_oe,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  input wire logic sda,
  // device status
  input wire logic busy,
  input wire logic nv_start
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] busy_cnt_reg;
  logic [3:0] since_stop_reg;
  ////////////////////////////////////////
  // cycles spent busy so far
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) busy_cnt_reg <= '0;
    else if (busy) busy_cnt_reg <= busy_cnt_reg + 32'h1;
    else busy_cnt_reg <= '0;
  end
  // cycles since the last stop on the wire, saturating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) since_stop_reg <= 4'hf;
    else if (scl && sda && !$past(sda)) since_stop_reg <= 4'h0;
    else if (since_stop_reg != 4'hf) since_stop_reg <= since_stop_reg + 4'h1;
  end
  ////////////////////////////////////////
  a_busy_quiet: assert property (busy |-> !d_sda_oe)
    else $error("device drove sda while busy");
  a_commit_busy: assert property (nv_start |-> ##[0:2] busy)
    else $error("commit without busy");
  a_commit_pulse: assert property (nv_start |=> !nv_start)
    else $error("commit pulse too long");
  a_busy_span: assert property ($fell(busy) |-> busy_cnt_reg == TWC_CYC)
    else $error("busy span wrong");
  a_busy_bound: assert property (busy |-> busy_cnt_reg < TWC_CYC)
    else $error("busy overran");
  a_commit_stop: assert property (nv_start |-> since_stop_reg < 4'h8)
    else $error("commit without a stop");
  a_drive_low: assert property ($rose(d_sda_oe) |-> !scl)
    else $error("sda taken while scl high");
  a_oe_hold: assert property (scl && $past(scl) |-> $stable(d_sda_oe))
    else $error("sda changed while scl high");
  a_stop_idle: assert property (since_stop_reg == 4'h2 |-> !d_sda_oe)
    else $error("sda held after stop");
  c_commit: cover property (nv_start);
  c_busy_end: cover property ($fell(busy));
  c_dev_drive: cover property ($rose(d_sda_oe));
endmodule

//--- rtc_eeprom_serial_access_bench.sv
// Purpose: host and device joined, driven through the command port
// Assumes: short write cycle, memory model kept here
// Notes: reads compare against what was written
`timescale 1ns/10ps
module rtc_eeprom_serial_access_bench;
  localparam int unsigned TWC = 64;
  logic clk, rst_n, cmd_valid, cmd_ccr, wr_valid, cmd_ready, wr_ready, rd_valid, done, err, busy, nv_start, err_seen;
  rsa_pkg::rsa_op_e cmd_op;
  logic [15:0] cmd_addr;
  logic [5:0] cmd_len;
  logic [7:0] wr_data, rd_data;
  logic [3:0] wp_blocks;
  logic [7:0] mem [1024];
  logic [7:0] wq[$];
  logic [7:0] rq[$];
  int n_errors, comparisons, nv_cnt, i;
  rsa_if link();
  rsa_host rsa_host_i (.clk(clk), .rst_n(rst_n), .bus(link.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_ccr(cmd_ccr), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_valid(wr_valid),
    .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .err(err));
  rsa_dev #(.TWC_CYC(TWC)) rsa_dev_i (.clk(clk), .rst_n(rst_n), .bus(link.dev), .wp_blocks(wp_blocks),
    .busy(busy), .nv_start(nv_start));
  rsa_props #(.TWC_CYC(TWC)) rsa_props_i (.clk(clk), .rst_n(rst_n), .scl(link.scl), .h_sda_o(link.h_sda_o),
    .h_sda_oe(link.h_sda_oe), .d_sda_o(link.d_sda_o), .d_sda_oe(link.d_sda_oe), .sda(link.sda), .busy(busy),
    .nv_start(nv_start));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(negedge clk) if (nv_start === 1'b1) nv_cnt++;
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one command, write bytes fed on wr_ready, read bytes gathered
  task automatic run(input rsa_pkg::rsa_op_e op, input logic c, input logic [15:0] a, input logic [5:0] n);
    int k;
    logic fin;
    k = 0;
    fin = 1'b0;
    rq = {};
    err_seen = 1'b0;
    do @(negedge clk); while (cmd_ready !== 1'b1);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_ccr <= c;
    cmd_addr <= a;
    cmd_len <= n;
    wr_data <= (wq.size() > 0) ? wq[0] : 8'h00;
    @(posedge clk);
    cmd_valid <= 1'b0;
    while (!fin) begin
      @(negedge clk);
      if (wr_ready === 1'b1) k++;
      if (rd_valid === 1'b1) rq.push_back(rd_data);
      if (err === 1'b1) err_seen = 1'b1;
      fin = (done === 1'b1);
      @(posedge clk);
      if (k < wq.size()) wr_data <= wq[k];
    end
  endtask
  task automatic wr(input logic c, input logic [15:0] a, input logic [5:0] n, input int nv);
    int b;
    logic [15:0] m, p;
    b = nv_cnt;
    m = c ? 16'h0007 : 16'h000f;
    run(rsa_pkg::OP_WRITE, c, a, n);
    for (int j = 0; j < n && nv != 0; j++) begin
      p = (a & ~m) | ((a + 16'(j)) & m);
      mem[{c, p[8:0]}] = wq[j];
    end
    chk(8'(nv_cnt - b), 8'(nv));
    chk({7'h0, err_seen}, 8'h00);
  endtask
  task automatic rd(input rsa_pkg::rsa_op_e op, input logic c, input logic [15:0] a, input logic [5:0] n,
    input logic [15:0] e);
    logic [15:0] p;
    run(op, c, a, n);
    chk(8'(rq.size()), {2'h0, n});
    for (int j = 0; j < n; j++) begin
      p = (e + 16'(j)) & (c ? 16'h003f : 16'h01ff);
      chk(rq[j], mem[{c, p[8:0]}]);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = rsa_pkg::OP_WRITE;
    cmd_ccr = 1'b0;
    cmd_addr = 16'h0000;
    cmd_len = 6'h00;
    wr_valid = 1'b1;
    wr_data = 8'h00;
    wp_blocks = 4'h0;
    n_errors = 0;
    comparisons = 0;
    nv_cnt = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    wq = {8'h5a};
    wr(1'b0, 16'h0123, 6'h01, 1);
    rd(rsa_pkg::OP_RAND_RD, 1'b0, 16'h0123, 6'h01, 16'h0123);
    wq = {};
    for (i = 0; i < 18; i++) wq.push_back(8'h10 + 8'(i));
    wr(1'b0, 16'h000a, 6'h12, 1);
    wq = {8'hc3};
    wr(1'b0, 16'h0010, 6'h01, 1);
    rd(rsa_pkg::OP_RAND_RD, 1'b0, 16'h0000, 6'h11, 16'h0000);
    run(rsa_pkg::OP_SET_ADDR, 1'b0, 16'h0123, 6'h01);
    rd(rsa_pkg::OP_CUR_RD, 1'b0, 16'h0000, 6'h01, 16'h0123);
    wq = {8'ha5};
    wr(1'b0, 16'h01ff, 6'h01, 1);
    rd(rsa_pkg::OP_RAND_RD, 1'b0, 16'h01ff, 6'h02, 16'h01ff);
    wp_blocks <= 4'h1;
    wq = {8'hee};
    wr(1'b0, 16'h0005, 6'h01, 0);
    wp_blocks <= 4'h0;
    rd(rsa_pkg::OP_RAND_RD, 1'b0, 16'h0005, 6'h01, 16'h0005);
    wq = {};
    for (i = 0; i < 8; i++) wq.push_back(8'h80 + 8'(i));
    wr(1'b1, 16'h0030, 6'h08, 3);
    rd(rsa_pkg::OP_RAND_RD, 1'b1, 16'h0030, 6'h08, 16'h0030);
    run(rsa_pkg::OP_WRITE, 1'b1, 16'h0030, 6'h03);
    chk({7'h0, err_seen}, 8'h01);
    stop_test;
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    stop_test;
  end
endmodule
